// ===== logic/mifc_edge_flags.sv
// Four edge-captured sticky request flags with mask, read-clear, write-one-clear.
// Assumes sources are synchronous to CLK_I.
`timescale 1ns/1ps
`default_nettype none
module mifc_edge_flags
  import mifc_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests and control
  input wire logic [WIDTH-1:0] req_i,
  input wire logic [WIDTH-1:0] enable_i,
  input wire logic read_clr_i,
  input wire logic [WIDTH-1:0] wr_clr_i,
  // State
  output logic [WIDTH-1:0] flags_o,
  output logic new_o
);

  logic [WIDTH-1:0] req_d_r;
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;
  wire [WIDTH-1:0] rise = req_i & ~req_d_r;
  // Mask alone gates storage, never the global enable
  wire [WIDTH-1:0] set = rise & enable_i;
  wire [WIDTH-1:0] clr = read_clr_i ? {WIDTH{1'b1}} : wr_clr_i;

  // ----------------------------------------
  // Set wins, so a request during service is kept
  // ----------------------------------------
  assign flags_nxt = (flags_r & ~clr) | set;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      req_d_r <= '0;
      flags_r <= '0;
    end
    else
    begin
      req_d_r <= req_i;
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;
  assign new_o = |set;

endmodule
`default_nettype wire

// ===== logic/mifc_pkg.sv
// Package for the masked interrupt flag controller.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
package mifc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] MIFC_OFS_FLAGS1 = 8'h00;
  localparam logic [7:0] MIFC_OFS_FLAGS2 = 8'h04;
  localparam logic [7:0] MIFC_OFS_MASK1 = 8'h08;
  localparam logic [7:0] MIFC_OFS_MASK2 = 8'h0C;
  localparam logic [7:0] MIFC_OFS_CTRL = 8'h10;
  localparam logic [7:0] MIFC_OFS_EVT = 8'h14;
  localparam logic [7:0] MIFC_OFS_EVT_MASK = 8'h18;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int MIFC_NSRC = 8;
  localparam int MIFC_GRP = 4;
  localparam int MIFC_BIT_CNT_ZERO = 3;
  localparam int MIFC_BIT_CNT_MATCH = 2;
  localparam int MIFC_BIT_PIN34 = 1;
  localparam int MIFC_BIT_PIN05 = 0;
  localparam int MIFC_BIT_ONE_HZ = 3;
  localparam int MIFC_BIT_FAST_TICK = 2;
  localparam int MIFC_BIT_LEVEL = 1;
  localparam int MIFC_BIT_SERIAL = 0;
  localparam int MIFC_CTRL_GIE = 0;
  localparam int MIFC_EVT_NEW = 0;
  localparam int MIFC_EVT_NUM = 1;
  localparam logic [3:0] MIFC_RST_NIB = 4'h0;
  localparam logic [1:0] MIFC_RESP_OKAY = 2'b00;
  localparam logic [1:0] MIFC_RESP_SLVERR = 2'b10;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic counter_zero;
    logic counter_match;
    logic port_pin34;
    logic port_pin05;
  } mifc_grp1_t;

  typedef struct packed {
    logic one_hertz;
    logic fast_tick;
    logic level_detect;
    logic serial_done;
  } mifc_grp2_t;

endpackage

// ===== logic/mifc_top.sv
// Top of the masked interrupt flag controller with AXI4-Lite registers.
// Assumes request sources and halt strobe come from logic on CLK_I.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Eight sources, each with own mask
// - Level detect and pin compare share flag
// - CPU interrupt needs flag and global enable
// - Flag set on masked rising edge
// - Reset clears masks and global enable
// - Reading flag register clears all its flags
// - Writing one clears that flag only
// - Requests during service are kept
// - Masked-off requests are discarded
// - Storage ignores global enable
// - Entering halt sets global enable
// - First flag register bit layout
// - Second flag register bit layout
// - First mask register read/write, reset zero
// - Second mask register read/write, reset zero
module mifc_top
  import mifc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Request sources, first group
  input wire logic COUNTER_ZERO_I,
  input wire logic COUNTER_MATCH_I,
  input wire logic PORT_PIN34_I,
  input wire logic PORT_PIN05_I,
  // Request sources, second group
  input wire logic ONE_HERTZ_I,
  input wire logic FAST_TICK_I,
  input wire logic SUPPLY_LEVEL_I,
  input wire logic PIN4_COMPARE_I,
  input wire logic SERIAL_DONE_I,
  // CPU side
  input wire logic HALT_ENTER_I,
  output logic CPU_IRQ_O,
  output logic GLOBAL_IRQ_ENABLE_O,
  output logic EVT_IRQ_O,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8)
  begin : g_bad_addr
    $error("ADDR_W must be 5 to 8");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  function automatic logic known(input logic [ADDR_W-1:0] a);
    known = hit(a, MIFC_OFS_FLAGS1) || hit(a, MIFC_OFS_FLAGS2) || hit(a, MIFC_OFS_MASK1)
      || hit(a, MIFC_OFS_MASK2) || hit(a, MIFC_OFS_CTRL) || hit(a, MIFC_OFS_EVT)
      || hit(a, MIFC_OFS_EVT_MASK);
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] mask1_r;
  logic [3:0] mask2_r;
  logic gie_r;
  logic gie_nxt;
  logic irq_r;
  logic [1:0] evt_r;
  logic [1:0] evt_nxt;
  logic [1:0] evt_mask_r;
  logic evt_irq_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic aw_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_held_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ----------------------------------------
  // Sources
  // ----------------------------------------
  mifc_grp1_t req1;
  mifc_grp2_t req2;
  assign req1.counter_zero = COUNTER_ZERO_I;
  assign req1.counter_match = COUNTER_MATCH_I;
  assign req1.port_pin34 = PORT_PIN34_I;
  assign req1.port_pin05 = PORT_PIN05_I;
  assign req2.one_hertz = ONE_HERTZ_I;
  assign req2.fast_tick = FAST_TICK_I;
  // Shared line: OR before the edge detector
  assign req2.level_detect = SUPPLY_LEVEL_I | PIN4_COMPARE_I;
  assign req2.serial_done = SERIAL_DONE_I;

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire aw_have = aw_held_r | S_AXI_AWVALID;
  wire w_have = w_held_r | S_AXI_WVALID;
  wire [ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : S_AXI_AWADDR;
  wire [31:0] wr_data = w_held_r ? wdata_r : S_AXI_WDATA;
  wire [3:0] wr_strb = w_held_r ? wstrb_r : S_AXI_WSTRB;
  wire wr_do = aw_have & w_have & ~bvalid_r;
  wire wr_lane0 = wr_do & wr_strb[0];
  wire wr_f1 = wr_lane0 & hit(wr_addr, MIFC_OFS_FLAGS1);
  wire wr_f2 = wr_lane0 & hit(wr_addr, MIFC_OFS_FLAGS2);
  wire wr_m1 = wr_lane0 & hit(wr_addr, MIFC_OFS_MASK1);
  wire wr_m2 = wr_lane0 & hit(wr_addr, MIFC_OFS_MASK2);
  wire wr_ct = wr_lane0 & hit(wr_addr, MIFC_OFS_CTRL);
  wire wr_ev = wr_lane0 & hit(wr_addr, MIFC_OFS_EVT);
  wire wr_em = wr_lane0 & hit(wr_addr, MIFC_OFS_EVT_MASK);

  // Hold off the next write until its response is taken
  assign S_AXI_AWREADY = ~aw_held_r & ~bvalid_r;
  assign S_AXI_WREADY = ~w_held_r & ~bvalid_r;

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  wire rd_do = S_AXI_ARVALID & S_AXI_ARREADY;
  assign S_AXI_ARREADY = ~rvalid_r;
  // Reading a flag register empties it
  wire rd_f1 = rd_do & hit(S_AXI_ARADDR, MIFC_OFS_FLAGS1);
  wire rd_f2 = rd_do & hit(S_AXI_ARADDR, MIFC_OFS_FLAGS2);

  // ----------------------------------------
  // Flag banks
  // ----------------------------------------
  logic [3:0] flags1;
  logic [3:0] flags2;
  logic new1;
  logic new2;

  mifc_edge_flags #(.WIDTH(MIFC_GRP)) u_flags1 (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .req_i(req1),
    .enable_i(mask1_r),
    .read_clr_i(rd_f1),
    .wr_clr_i(wr_f1 ? wr_data[3:0] : 4'h0),
    .flags_o(flags1),
    .new_o(new1)
  );

  mifc_edge_flags #(.WIDTH(MIFC_GRP)) u_flags2 (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .req_i(req2),
    .enable_i(mask2_r),
    .read_clr_i(rd_f2),
    .wr_clr_i(wr_f2 ? wr_data[3:0] : 4'h0),
    .flags_o(flags2),
    .new_o(new2)
  );

  // ----------------------------------------
  // Global enable and interrupt line
  // ----------------------------------------
  // Halt wins over a software clear in the same cycle
  assign gie_nxt = HALT_ENTER_I ? 1'b1 : (wr_ct ? wr_data[MIFC_CTRL_GIE] : gie_r);

  // No priority among sources; software sorts it out
  wire any_flag = |{flags1, flags2};

  // ----------------------------------------
  // Event status
  // ----------------------------------------
  // Event status: new stored request, and new stored requests in both banks in the same cycle
  wire [1:0] evt_set = {new1 & new2, new1 | new2};
  assign evt_nxt = (evt_r & ~(wr_ev ? wr_data[1:0] : 2'b00)) | evt_set;

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mask1_r <= MIFC_RST_NIB;
      mask2_r <= MIFC_RST_NIB;
      gie_r <= 1'b0;
      irq_r <= 1'b0;
      evt_r <= 2'b00;
      evt_mask_r <= 2'b00;
      evt_irq_r <= 1'b0;
    end
    else
    begin
      if (wr_m1)
        mask1_r <= wr_data[3:0];
      if (wr_m2)
        mask2_r <= wr_data[3:0];
      if (wr_em)
        evt_mask_r <= wr_data[1:0];
      gie_r <= gie_nxt;
      irq_r <= gie_r & any_flag;
      evt_r <= evt_nxt;
      // Registered like the CPU line, so neither interrupt output glitches
      evt_irq_r <= |(evt_r & evt_mask_r);
    end
  end

  // ----------------------------------------
  // Bus bookkeeping
  // ----------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= MIFC_RESP_OKAY;
    end
    else
    begin
      if (wr_do)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= known(wr_addr) ? MIFC_RESP_OKAY : MIFC_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_r <= 1'b1;
          awaddr_r <= S_AXI_AWADDR;
        end
        if (w_take)
        begin
          w_held_r <= 1'b1;
          wdata_r <= S_AXI_WDATA;
          wstrb_r <= S_AXI_WSTRB;
        end
        if (bvalid_r && S_AXI_BREADY)
          bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // All state comes in as arguments, so the assignment follows every change
  function automatic logic [31:0] rd_word(
    input logic [ADDR_W-1:0] a,
    input logic [3:0] f1,
    input logic [3:0] f2,
    input logic [3:0] m1,
    input logic [3:0] m2,
    input logic g,
    input logic [1:0] ev,
    input logic [1:0] em
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit(a, MIFC_OFS_FLAGS1))
      w[3:0] = f1;
    else if (hit(a, MIFC_OFS_FLAGS2))
      w[3:0] = f2;
    else if (hit(a, MIFC_OFS_MASK1))
      w[3:0] = m1;
    else if (hit(a, MIFC_OFS_MASK2))
      w[3:0] = m2;
    else if (hit(a, MIFC_OFS_CTRL))
      w[MIFC_CTRL_GIE] = g;
    else if (hit(a, MIFC_OFS_EVT))
      w[1:0] = ev;
    else if (hit(a, MIFC_OFS_EVT_MASK))
      w[1:0] = em;
    rd_word = w;
  endfunction

  // Unmapped addresses read as zero
  wire [31:0] rd_mux = rd_word(S_AXI_ARADDR, flags1, flags2, mask1_r, mask2_r, gie_r, evt_r,
    evt_mask_r);

  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= MIFC_RESP_OKAY;
    end
    else if (rd_do)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= known(S_AXI_ARADDR) ? MIFC_RESP_OKAY : MIFC_RESP_SLVERR;
    end
    else if (rvalid_r && S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign CPU_IRQ_O = irq_r;
  assign GLOBAL_IRQ_ENABLE_O = gie_r;
  assign EVT_IRQ_O = evt_irq_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

endmodule
`default_nettype wire

// ===== testbench/mifc_chk_sva.sv
// Assertion checker on the top ports of the interrupt flag controller.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module mifc_chk
  import mifc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // CPU side
  input wire logic HALT_ENTER_I,
  input wire logic CPU_IRQ_O,
  input wire logic GLOBAL_IRQ_ENABLE_O,
  // Bus
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  AST_IRQ_NEEDS_GIE: assert property (CPU_IRQ_O |-> $past(GLOBAL_IRQ_ENABLE_O))
    else $error("cpu irq without global enable");
  AST_RESET_QUIET: assert property (disable iff (1'b0) RST_I |-> !GLOBAL_IRQ_ENABLE_O && !CPU_IRQ_O)
    else $error("enable or irq high in reset");
  AST_HALT_SETS_GIE: assert property (HALT_ENTER_I |=> GLOBAL_IRQ_ENABLE_O)
    else $error("halt did not set global enable");
  AST_W_REFUSED: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while response pending");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  AST_R_LATENCY: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  AST_R_UPPER: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h000_0000)
    else $error("upper read bits not zero");
endmodule
bind mifc_top mifc_chk mifc_chk_i (.CLK_I, .RST_I, .HALT_ENTER_I, .CPU_IRQ_O, .GLOBAL_IRQ_ENABLE_O,
  .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA);
`default_nettype wire

// ===== testbench/mifc_src_model.sv
// Model of the request sources and the CPU halt strobe.
// Assumes its tasks are called just after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module mifc_src_model
(
  // Clock
  input wire logic clk_i,
  // Requests and halt
  output var logic [8:0] req_o,
  output var logic halt_o
);
  // ----
  // Stimulus
  // ----
  initial req_o = 9'h000;
  initial halt_o = 1'b0;
  // Sources drop back low, so each call is one clean rising edge
  task automatic pulse_bits(input logic [8:0] b);
    req_o <= b;
    @(posedge clk_i);
    req_o <= 9'h000;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int k);
    pulse_bits(9'h001 << k);
  endtask
  task automatic do_halt();
    halt_o <= 1'b1;
    @(posedge clk_i);
    halt_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== testbench/test_masked_irq_flag_controller.sv
// Self-checking bench for the masked interrupt flag controller.
// Assumes the source model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_masked_irq_flag_controller
  import mifc_pkg::*;
;
  // ----
  // Signals
  // ----
  logic clk, rst, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid, irq, gie, halt;
  logic [7:0] awaddr, araddr, a;
  logic [31:0] wdata, rdata, rd_v, e;
  logic [1:0] bresp, rresp, resp_v;
  logic [8:0] req;
  logic evt_irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  mifc_src_model mifc_src_model_i (.clk_i(clk), .req_o(req), .halt_o(halt));
  mifc_top mifc_top_i (.CLK_I(clk), .RST_I(rst), .COUNTER_ZERO_I(req[3]), .COUNTER_MATCH_I(req[2]),
    .PORT_PIN34_I(req[1]), .PORT_PIN05_I(req[0]), .ONE_HERTZ_I(req[7]), .FAST_TICK_I(req[6]),
    .SUPPLY_LEVEL_I(req[5]), .PIN4_COMPARE_I(req[8]), .SERIAL_DONE_I(req[4]), .HALT_ENTER_I(halt),
    .CPU_IRQ_O(irq), .GLOBAL_IRQ_ENABLE_O(gie), .EVT_IRQ_O(evt_irq), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----
  // Bus tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bit da = 0;
    bit dw = 0;
    awaddr <= ad;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk);
      da = da | awrdy;
      dw = dw | wrdy;
      if (da) awv <= 1'b0;
      if (dw) wv <= 1'b0;
    end
    while (!(da && dw));
    do @(posedge clk); while (!bvalid);
    bready <= 1'b1;
    @(posedge clk);
    resp_v = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad);
    araddr <= ad;
    arv <= 1'b1;
    do @(posedge clk); while (!arrdy);
    arv <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b1;
    @(posedge clk);
    rd_v = rdata;
    resp_v = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] x, input string nm);
    rd(ad);
    chk(nm, rd_v, x);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // ----
  // Sequence
  // ----
  initial
  begin
    rst = 1'b1;
    {awv, wv, bready, arv, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("gie", 32'(gie), 0);
    rdchk(MIFC_OFS_MASK1, 0, "mask1");
    rdchk(MIFC_OFS_MASK2, 0, "mask2");
    rdchk(MIFC_OFS_CTRL, 0, "ctrl");
    for (int k = 0; k < 9; k++) mifc_src_model_i.pulse(k);
    rdchk(MIFC_OFS_FLAGS1, 0, "masked1");
    rdchk(MIFC_OFS_FLAGS2, 0, "masked2");
    wr(MIFC_OFS_MASK1, 32'h0000_000F);
    chk("wr_resp", 32'(resp_v), 32'(MIFC_RESP_OKAY));
    wr(MIFC_OFS_MASK2, 32'h0000_000F);
    rdchk(MIFC_OFS_MASK1, 32'h0000_000F, "mask1");
    rdchk(MIFC_OFS_MASK2, 32'h0000_000F, "mask2");
    for (int k = 0; k < 9; k++)
    begin
      a = (k < 4) ? MIFC_OFS_FLAGS1 : MIFC_OFS_FLAGS2;
      e = (k == 8) ? 32'h0000_0002 : (32'h0000_0001 << (k % 4));
      mifc_src_model_i.pulse(k);
      chk("irq_off", 32'(irq), 0);
      rdchk(a, e, "flag");
      rdchk(a, 0, "cleared");
    end
    wr(MIFC_OFS_CTRL, 32'h0000_0001);
    mifc_src_model_i.pulse(0);
    mifc_src_model_i.pulse(3);
    mifc_src_model_i.pulse(7);
    chk("irq_on", 32'(irq), 1);
    wr(MIFC_OFS_FLAGS1, 32'h0000_0001);
    rdchk(MIFC_OFS_FLAGS1, 32'h0000_0008, "w1c");
    chk("irq_pend", 32'(irq), 1);
    rdchk(MIFC_OFS_FLAGS2, 32'h0000_0008, "svc2");
    repeat (2) @(posedge clk);
    chk("irq_idle", 32'(irq), 0);
    mifc_src_model_i.pulse(4);
    @(posedge clk);
    chk("irq_new", 32'(irq), 1);
    wr(MIFC_OFS_FLAGS2, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'(irq), 0);
    wr(MIFC_OFS_CTRL, 0);
    chk("gie_off", 32'(gie), 0);
    mifc_src_model_i.do_halt();
    chk("gie_halt", 32'(gie), 1);
    rdchk(MIFC_OFS_CTRL, 1, "ctrl_halt");
    rd(8'h40);
    chk("bad_resp", 32'(resp_v), 32'(MIFC_RESP_SLVERR));
    chk("bad_data", rd_v, 0);
    wr(8'h48, 32'h0000_0000);
    chk("bad_wr", 32'(resp_v), 32'(MIFC_RESP_SLVERR));
    rdchk(MIFC_OFS_MASK1, 32'h0000_000F, "bad_wr_kept");
    rdchk(MIFC_OFS_EVT, 32'h0000_0001, "evt_new");
    chk("evt_irq_off", 32'(evt_irq), 0);
    wr(MIFC_OFS_EVT_MASK, 32'h0000_0003);
    rdchk(MIFC_OFS_EVT_MASK, 32'h0000_0003, "evt_mask");
    chk("evt_irq_on", 32'(evt_irq), 1);
    wr(MIFC_OFS_EVT, 32'h0000_0001);
    rdchk(MIFC_OFS_EVT, 0, "evt_w1c");
    chk("evt_irq_clr", 32'(evt_irq), 0);
    mifc_src_model_i.pulse_bits(9'h011);
    rdchk(MIFC_OFS_EVT, 32'h0000_0003, "evt_both");
    chk("evt_irq_both", 32'(evt_irq), 1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("gie_rst", 32'(gie), 0);
    rdchk(MIFC_OFS_MASK1, 0, "mask1_rst");
    rdchk(MIFC_OFS_EVT, 0, "evt_rst");
    chk("evt_irq_rst", 32'(evt_irq), 0);
    close_out();
  end
endmodule
`default_nettype wire
